// >>> hdl/osc_clock_regs.svh
// Register map, field positions and timing counts of the clock source block
`ifndef OSC_CLOCK_REGS_SVH
`define OSC_CLOCK_REGS_SVH

// Byte addresses on the register bus
`define OSC_CTRL_ADDR       16'h0000
`define OSC_STAT_ADDR       16'h0004
`define OSC_OPT_ADDR        16'hFFD0

// Option byte: type select in the top bit, erased state all ones
`define OSC_OPT_TYPE_BIT    7
`define OSC_OPT_ERASED      8'hFF

// Control register fields and reset value
`define OSC_CTRL_STOP_DIS   0
`define OSC_CTRL_PFE        1
`define OSC_CTRL_RESET      2'h0

// Status register fields
`define OSC_STAT_SRC_ON     0
`define OSC_STAT_HALVED     1
`define OSC_STAT_SLOW_ON    2
`define OSC_STAT_XTAL       3

// Timing: system clock and nominal slow clock rate, both in Hz
`define OSC_CLK_HZ          100000000
`define OSC_SLOW_HZ         50000
`define OSC_SLOW_HALF       (`OSC_CLK_HZ / (2 * `OSC_SLOW_HZ))
`define OSC_CNT_W           12

`endif

// >>> hdl/osc_clock_pkg.sv
// Types shared by the clock source block
package osc_clock_pkg;
`include "osc_clock_regs.svh"

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

    typedef struct packed {
        bus_state_t             bus;
        logic [31:0]            rdata;
        logic [1:0]             ctrl;
        logic                   src_d;
        logic                   gate_full;
        logic                   full;
        logic                   halved;
        logic                   gate_slow;
        logic                   slow_ph;
        logic [`OSC_CNT_W-1:0]  cnt;
        logic                   xtal_en;
        logic                   rc_en;
        logic                   pin_o;
        logic                   pin_oe;
        logic                   kbi;
        logic                   slow_q;
        logic                   wreq;
        logic                   live;
    } osc_state_t;
endpackage

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("pin_sync WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> hdl/oscillator_clock_select_gating.sv
// Clock source selection, division, gating and shared pin control
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "osc_clock_regs.svh"
module oscillator_clock_select_gating
    import osc_clock_pkg::*;
#(
    parameter logic [7:0] OPTION_BYTE_INIT = `OSC_OPT_ERASED,
    parameter int         SLOW_HALF        = `OSC_SLOW_HALF
) (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // From the system integration unit
    input  wire logic        oscillator_enable_request_in,
    input  wire logic        wait_mode_in,
    input  wire logic        stop_mode_in,
    input  wire logic        break_state_in,
    // Port bit six drive from port logic
    input  wire logic        port_a_bit_six_data_in,
    input  wire logic        port_a_bit_six_dir_in,
    // Pins
    input  wire logic        oscillator_input_pin_in,
    input  wire logic        oscillator_output_pin_in,
    output logic             oscillator_output_pin_out,
    output logic             oscillator_output_pin_oe_out,
    // Analog oscillator enables
    output logic             crystal_enable_out,
    output logic             rc_enable_out,
    // Clocks and keyboard input six to consumers
    output logic             full_rate_clock_out,
    output logic             halved_clock_out,
    output logic             internal_slow_clock_out,
    output logic             keyboard_input_six_out
);
    localparam logic [`OSC_CNT_W-1:0] SLOW_LAST = SLOW_HALF[`OSC_CNT_W-1:0] - 1'b1;

    generate
        if (SLOW_HALF < 1 || SLOW_HALF >= (1 << `OSC_CNT_W)) begin : g_bad_half
            $error("SLOW_HALF out of range for the slow clock counter");
        end
    endgenerate

    osc_state_t st;
    osc_state_t next_st;
    logic [1:0] pins_sync;
    logic       src;
    logic       pin_sense;
    logic       type_sel;
    logic       run_src;
    logic       run_slow;
    logic       bus_req;

    // Both pin inputs pass two flops before use
    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .async_in ({oscillator_output_pin_in, oscillator_input_pin_in}),
        .sync_out (pins_sync)
    );

    // Decodes a bus address into a register hit
    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] r);
        return a == r;
    endfunction

    // Nonvolatile option: fixed by parameter, no reset path
    assign type_sel  = OPTION_BYTE_INIT[`OSC_OPT_TYPE_BIT];
    // Crystal, external clock or RC all arrive on the input pin
    assign src       = pins_sync[0];
    assign pin_sense = pins_sync[1];
    assign bus_req   = avs_read_in | avs_write_in;

    // Source runs on request, except stop outside break
    assign run_src  = oscillator_enable_request_in
                    & ~(stop_mode_in & ~break_state_in);
    // Slow clock halts only in stop with the disable bit set
    assign run_slow = ~(stop_mode_in & ~break_state_in
                    & st.ctrl[`OSC_CTRL_STOP_DIS]);

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;

        // Exclusive oscillator enables
        next_st.xtal_en = run_src & type_sel;
        next_st.rc_en   = run_src & ~type_sel;

        // Full-rate gate moves only while source is low
        next_st.src_d = src;
        if (!src) begin
            next_st.gate_full = run_src;
        end
        // Wait mode does not enter this path
        next_st.full = src & st.gate_full;

        // Halved toggles on source rise, finishing a high phase
        if (src && !st.src_d && (st.gate_full || st.halved)) begin
            next_st.halved = ~st.halved;
        end

        // Free-running slow clock divider
        if (st.cnt == SLOW_LAST) begin
            next_st.cnt     = '0;
            next_st.slow_ph = ~st.slow_ph;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
        if (!st.slow_ph) begin
            next_st.gate_slow = run_slow;
        end

        // Shared output pin role
        if (type_sel) begin
            next_st.pin_o  = ~src;
            next_st.pin_oe = 1'b1;
            next_st.kbi    = 1'b1;
        end else if (!st.ctrl[`OSC_CTRL_PFE]) begin
            next_st.pin_o  = st.full;
            next_st.pin_oe = 1'b1;
            next_st.kbi    = 1'b1;
        end else begin
            next_st.pin_o  = port_a_bit_six_data_in;
            next_st.pin_oe = port_a_bit_six_dir_in;
            next_st.kbi    = pin_sense;
        end

        // Register bus: one wait cycle, then a one-cycle answer
        case (st.bus)
            BUS_IDLE: begin
                if (bus_req) begin
                    next_st.bus   = BUS_ACK;
                    next_st.rdata = '0;
                    if (addr_is(avs_address_in, `OSC_CTRL_ADDR)) begin
                        next_st.rdata[1:0] = st.ctrl;
                    end else if (addr_is(avs_address_in, `OSC_STAT_ADDR)) begin
                        next_st.rdata[`OSC_STAT_SRC_ON]  = st.gate_full;
                        next_st.rdata[`OSC_STAT_HALVED]  = st.halved;
                        next_st.rdata[`OSC_STAT_SLOW_ON] = st.gate_slow;
                        next_st.rdata[`OSC_STAT_XTAL]    = type_sel;
                    end else if (addr_is(avs_address_in, `OSC_OPT_ADDR)) begin
                        next_st.rdata[7:0] = OPTION_BYTE_INIT;
                    end
                end
            end
            BUS_ACK: begin
                next_st.bus = BUS_IDLE;
                if (avs_write_in && avs_byteenable_in[0]
                        && addr_is(avs_address_in, `OSC_CTRL_ADDR)) begin
                    next_st.ctrl = avs_writedata_in[1:0];
                end
            end
            default: begin
                next_st.bus = BUS_IDLE;
            end
        endcase
        // Output copies registered here so every output leaves a flop
        next_st.slow_q = next_st.slow_ph & next_st.gate_slow;
        next_st.wreq   = (next_st.bus != BUS_ACK);
        next_st.live   = 1'b1;
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            st           <= '0;
            st.bus       <= BUS_IDLE;
            st.ctrl      <= `OSC_CTRL_RESET;
            st.gate_slow <= 1'b1;
            st.kbi       <= 1'b1;
            st.wreq      <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign avs_readdata_out             = st.rdata;
    assign avs_waitrequest_out          = st.wreq;
    assign oscillator_output_pin_out    = st.pin_o;
    assign oscillator_output_pin_oe_out = st.pin_oe;
    assign crystal_enable_out           = st.xtal_en;
    assign rc_enable_out                = st.rc_en;
    assign full_rate_clock_out          = st.full;
    assign halved_clock_out             = st.halved;
    assign internal_slow_clock_out      = st.slow_q;
    assign keyboard_input_six_out       = st.kbi;

    // Checks
    sequence s_src_rise;
        src && !st.src_d;
    endsequence

    sequence s_stopped;
        stop_mode_in && !break_state_in;
    endsequence

    sequence s_taken;
        (avs_read_in || avs_write_in) && (st.bus == BUS_IDLE);
    endsequence

    sequence s_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    property p_sel_type;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        oscillator_enable_request_in && !stop_mode_in
            |=> (crystal_enable_out == type_sel) && (rc_enable_out == !type_sel);
    endproperty
    a_sel_type: assert property (p_sel_type) else $error("wrong oscillator enabled");

    property p_never_both;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        !(crystal_enable_out && rc_enable_out);
    endproperty
    a_never_both: assert property (p_never_both) else $error("both oscillators on");

    property p_enable_req;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        !oscillator_enable_request_in |=> !crystal_enable_out && !rc_enable_out;
    endproperty
    a_enable_req: assert property (p_enable_req) else $error("oscillator on unrequested");

    property p_pin_xtal;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        type_sel |=> oscillator_output_pin_oe_out
            && (oscillator_output_pin_out == !$past(src)) && keyboard_input_six_out;
    endproperty
    a_pin_xtal: assert property (p_pin_xtal) else $error("pin not inverting input");

    property p_pin_rc;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        !type_sel && !st.ctrl[`OSC_CTRL_PFE] && $stable(st.ctrl)
            |=> oscillator_output_pin_oe_out
            && (oscillator_output_pin_out == $past(full_rate_clock_out));
    endproperty
    a_pin_rc: assert property (p_pin_rc) else $error("pin not driving RC clock");

    property p_halved_edge;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        $changed(halved_clock_out) |-> $past(src && !st.src_d);
    endproperty
    a_halved_edge: assert property (p_halved_edge) else $error("halved moved off edge");

    property p_halved_runs;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_src_rise ##0 st.gate_full |=> $changed(halved_clock_out);
    endproperty
    a_halved_runs: assert property (p_halved_runs) else $error("halved did not toggle");

    property p_stop_quiet;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_stopped ##0 !src ##1 s_stopped ##0 !src |=> !st.gate_full ##1 !full_rate_clock_out;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("source ran in stop");

    property p_slow_kept;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        !st.ctrl[`OSC_CTRL_STOP_DIS] && !st.slow_ph |=> st.gate_slow;
    endproperty
    a_slow_kept: assert property (p_slow_kept) else $error("slow clock gated");

    property p_break_slow;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        break_state_in && !st.slow_ph |=> st.gate_slow;
    endproperty
    a_break_slow: assert property (p_break_slow) else $error("slow clock cut in break");

    property p_clean_gate;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        $changed(st.gate_full) |-> !$past(src);
    endproperty
    a_clean_gate: assert property (p_clean_gate) else $error("gate moved while high");

    property p_full_follows;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        st.gate_full && $stable(st.gate_full) |=> full_rate_clock_out == $past(src);
    endproperty
    a_full_follows: assert property (p_full_follows) else $error("full-rate mismatch");

    property p_wait_run;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        wait_mode_in && oscillator_enable_request_in && !stop_mode_in
            |=> crystal_enable_out || rc_enable_out;
    endproperty
    a_wait_run: assert property (p_wait_run) else $error("oscillator cut in wait");

    property p_stop_off;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_stopped |=> !crystal_enable_out && !rc_enable_out;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("oscillator on in stop");

    property p_slow_cut;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_stopped ##0 (st.ctrl[`OSC_CTRL_STOP_DIS] && !st.slow_ph)
            |=> !st.gate_slow;
    endproperty
    a_slow_cut: assert property (p_slow_cut) else $error("slow clock ran in stop");

    property p_slow_div;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        st.cnt == SLOW_LAST |=> (st.cnt == '0) && $changed(st.slow_ph);
    endproperty
    a_slow_div: assert property (p_slow_div) else $error("slow divider slipped");

    property p_slow_edge;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        $changed(st.gate_slow) |-> !$past(st.slow_ph);
    endproperty
    a_slow_edge: assert property (p_slow_edge) else $error("slow gate moved high");

    property p_pin_port;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        !type_sel && st.ctrl[`OSC_CTRL_PFE]
            |=> (oscillator_output_pin_out == $past(port_a_bit_six_data_in))
            && (oscillator_output_pin_oe_out == $past(port_a_bit_six_dir_in))
            && (keyboard_input_six_out == $past(pin_sense));
    endproperty
    a_pin_port: assert property (p_pin_port) else $error("pin not in port role");

    property p_bus_ans;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_taken |=> s_answer;
    endproperty
    a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");

    property p_ctrl_wr;
        @(posedge clock_in) disable iff (srst_in || !st.live)
        s_taken ##1 (avs_write_in && avs_byteenable_in[0]
            && (avs_address_in == `OSC_CTRL_ADDR))
            |=> st.ctrl == $past(avs_writedata_in[1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

endmodule

// >>> test/osc_far_side_model.sv
// Oscillator circuit on the input pin and clock consumers counting edges
`timescale 1ns/1ps
module osc_far_side_model #(
    parameter int HALF = 8
) (
    input  wire logic        clock_in,
    input  wire logic        clear_in,
    input  wire logic        xtal_en_in,
    input  wire logic        rc_en_in,
    input  wire logic [2:0]  clocks_in,
    output logic             osc_pin_out = 1'h0,
    output logic [47:0]      clk_cnt_out = 48'h0
);
    int         ph = 0;
    logic [2:0] last = 3'h0;
    // Pin toggles only while exactly one circuit is enabled; edges counted
    always @(posedge clock_in) begin
        if (xtal_en_in ^ rc_en_in) begin
            ph <= (ph == HALF - 1) ? 0 : ph + 1;
            if (ph == HALF - 1)
                osc_pin_out <= ~osc_pin_out;
        end
        last <= clocks_in;
        if (clear_in)
            clk_cnt_out <= 48'h0;
        else
            for (int i = 0; i < 3; i++)
                if (clocks_in[i] & ~last[i])
                    clk_cnt_out[16*i +: 16] <= clk_cnt_out[16*i +: 16] + 16'h1;
    end
endmodule

// >>> test/testbench.sv
// Bench for crystal and RC builds of the clock source block
`timescale 1ns/1ps
`include "osc_clock_regs.svh"
module testbench;
    localparam int HALF = 8;
    localparam int SLOW = 4;
    localparam int W    = 160;
    localparam int EF   = W / (2 * HALF);
    localparam int ES   = W / (2 * SLOW);
    logic        clock_in = 1'h0;
    logic        srst_in  = 1'h1;
    logic [15:0] addr     = 16'h0;
    logic [31:0] wdata    = 32'h0;
    logic        rd       = 1'h0;
    logic        wr       = 1'h0;
    logic        osc_en   = 1'h0;
    logic        wait_m   = 1'h0;
    logic        stop_m   = 1'h0;
    logic        brk      = 1'h0;
    logic        pdata    = 1'h0;
    logic        pdir     = 1'h0;
    logic        kpin     = 1'h1;
    logic        clr      = 1'h0;
    logic [31:0] rdata [2];
    logic        wreq [2], pin_o [2], pin_oe [2], pin_w [2], xen [2], rcen [2];
    logic        full [2], halved [2], slow [2], kbi [2], osc [2];
    logic [47:0] cnt [2];
    logic [31:0] d0, d1;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    // Unit 0 is a crystal build, unit 1 an RC build with low bits kept at one
    for (genvar g = 0; g < 2; g++) begin : unit
        assign pin_w[g] = pin_oe[g] ? pin_o[g] : kpin;
        oscillator_clock_select_gating #(
            .OPTION_BYTE_INIT(g == 0 ? 8'hFF : 8'h7F), .SLOW_HALF(SLOW)
        ) oscillator_clock_select_gating_inst (
            .clock_in(clock_in), .srst_in(srst_in), .avs_address_in(addr),
            .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
            .avs_byteenable_in(4'hF), .avs_readdata_out(rdata[g]),
            .avs_waitrequest_out(wreq[g]), .oscillator_enable_request_in(osc_en),
            .wait_mode_in(wait_m), .stop_mode_in(stop_m), .break_state_in(brk),
            .port_a_bit_six_data_in(pdata), .port_a_bit_six_dir_in(pdir),
            .oscillator_input_pin_in(osc[g]), .oscillator_output_pin_in(pin_w[g]),
            .oscillator_output_pin_out(pin_o[g]),
            .oscillator_output_pin_oe_out(pin_oe[g]),
            .crystal_enable_out(xen[g]), .rc_enable_out(rcen[g]),
            .full_rate_clock_out(full[g]), .halved_clock_out(halved[g]),
            .internal_slow_clock_out(slow[g]), .keyboard_input_six_out(kbi[g]));
        osc_far_side_model #(.HALF(HALF)) osc_far_side_model_inst (
            .clock_in(clock_in), .clear_in(clr), .xtal_en_in(xen[g]),
            .rc_en_in(rcen[g]), .clocks_in({slow[g], halved[g], full[g]}),
            .osc_pin_out(osc[g]), .clk_cnt_out(cnt[g]));
    end

    // Clock and hang guard
    always #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One bus cycle; both units answer in step, unit 0 paces the handshake
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
        addr  <= a;
        wdata <= wd;
        rd    <= ~w;
        wr    <= w;
        do @(posedge clock_in); while (wreq[0] !== 1'h0);
        d0 = rdata[0];
        d1 = rdata[1];
        rd <= 1'h0;
        wr <= 1'h0;
        @(posedge clock_in);
    endtask

    // Counts consumer edges over a window and compares within one edge
    task automatic rates(input int g, input int ef, input int eh, input int es);
        int e [3];
        logic [15:0] lo, hi, got;
        e = '{ef, eh, es};
        repeat (40) @(posedge clock_in);
        clr <= 1'h1;
        @(posedge clock_in);
        clr <= 1'h0;
        repeat (W) @(posedge clock_in);
        for (int i = 0; i < 3; i++) begin
            got = cnt[g][16*i +: 16];
            lo = (e[i] == 0) ? 16'h0 : 16'(e[i] - 1);
            hi = 16'(e[i] + 1);
            total_checks++;
            if (((got >= lo) && (got <= hi)) !== 1'h1) begin
                n_mismatch++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, e[i]);
            end
        end
    endtask

    task automatic t_regs();
        bus(1'h0, `OSC_OPT_ADDR, 32'h0);
        chk(d0, 32'hFF);
        chk(d1, 32'h7F);
        bus(1'h0, `OSC_STAT_ADDR, 32'h0);
        chk({d0[3], d1[3]}, 32'h2);
        bus(1'h0, `OSC_CTRL_ADDR, 32'h0);
        chk(d0, 32'h0);
        bus(1'h1, `OSC_OPT_ADDR, 32'h0);
        bus(1'h1, 16'h0008, 32'h3);
        bus(1'h0, 16'h0008, 32'h0);
        chk(d0, 32'h0);
        bus(1'h1, `OSC_CTRL_ADDR, 32'h3);
        bus(1'h0, `OSC_CTRL_ADDR, 32'h0);
        chk(d0, 32'h3);
        srst_in <= 1'h1;
        repeat (3) @(posedge clock_in);
        srst_in <= 1'h0;
        @(posedge clock_in);
        bus(1'h0, `OSC_CTRL_ADDR, 32'h0);
        chk(d0, 32'h0);
        bus(1'h0, `OSC_OPT_ADDR, 32'h0);
        chk(d0, 32'hFF);
        $display("t_regs done");
    endtask

    task automatic t_xtal();
        rates(0, 0, 0, ES);
        chk({xen[0], rcen[0], xen[1], rcen[1]}, 32'h0);
        osc_en <= 1'h1;
        rates(0, EF, EF / 2, ES);
        chk({xen[0], rcen[0], xen[1], rcen[1]}, 32'h9);
        @(posedge osc[0]);
        repeat (6) @(posedge clock_in);
        chk({pin_o[0], pin_oe[0], kbi[0], full[0]}, 32'h7);
        $display("t_xtal done");
    endtask

    task automatic t_modes();
        wait_m <= 1'h1;
        rates(0, EF, EF / 2, ES);
        wait_m <= 1'h0;
        stop_m <= 1'h1;
        rates(0, 0, 0, ES);
        bus(1'h1, `OSC_CTRL_ADDR, 32'h1);
        rates(0, 0, 0, 0);
        brk <= 1'h1;
        rates(0, EF, EF / 2, ES);
        brk <= 1'h0;
        stop_m <= 1'h0;
        bus(1'h1, `OSC_CTRL_ADDR, 32'h0);
        rates(1, EF, EF / 2, ES);
        $display("t_modes done");
    endtask

    task automatic t_rc();
        logic prev;
        prev = full[1];
        repeat (32) begin
            @(posedge clock_in);
            chk({pin_o[1], pin_oe[1]}, {prev, 1'h1});
            prev = full[1];
        end
        bus(1'h1, `OSC_CTRL_ADDR, 32'h2);
        pdir  <= 1'h1;
        pdata <= 1'h1;
        repeat (4) @(posedge clock_in);
        chk({pin_o[1], pin_oe[1], pin_oe[0]}, 32'h7);
        pdir <= 1'h0;
        kpin <= 1'h0;
        repeat (6) @(posedge clock_in);
        chk({pin_oe[1], kbi[1], kbi[0]}, 32'h1);
        $display("t_rc done");
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clock_in);
        srst_in <= 1'h0;
        @(posedge clock_in);
        t_regs();
        t_xtal();
        t_modes();
        t_rc();
        complete_run();
    end
endmodule
